// file: rtl/xcvr_pwr_pkg.sv
// package: channel counts, timing constants and carrier types for the transceiver power control
package xcvr_pwr_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned NUM_TX = 5;
  localparam int unsigned NUM_RX = 3;
  // inactivity time in seconds and its count of cycles
  localparam int unsigned IDLE_SEC = 30;
  localparam longint unsigned IDLE_CYCLES = longint'(IDLE_SEC) * longint'(CLK_HZ);
  // invalid-level time in microseconds, least time rounds up
  localparam int unsigned INVALID_US = 60;
  localparam int unsigned INVALID_CYCLES = (INVALID_US * (CLK_HZ / 1_000_000)) + 1;
  // valid-level recovery in microseconds
  localparam int unsigned VALID_US = 1;
  localparam int unsigned VALID_CYCLES = VALID_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FIFO_DEPTH = 8;

  // operating modes
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_AUTO_DOWN,
    MODE_MANUAL_DOWN
  } pwr_mode_t;

  // synchronised inputs that travel together
  typedef struct packed {
    logic [NUM_TX-1:0] tx;
    logic [NUM_RX-1:0] rx;
    logic [NUM_RX-1:0] rx_valid;
    logic monitor;
  } line_in_t;
endpackage : xcvr_pwr_pkg

// file: rtl/sync_fifo.sv
// file: small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module sync_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // =====================================================
  // pointer and count update
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = mem[st.rd_ptr];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage is not reset, only the pointers matter
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data;
    end
  end
endmodule : sync_fifo

// file: rtl/serial_transceiver_power_control.sv
// file: powerdown and channel-enable control for a multi-channel serial line transceiver
`timescale 1ns/10ps
// What this block does
// [R1] enabled transmitter drives inverse of its input
// [R2] any powerdown tri-states every transmitter output
// [R3] undriven transmitter input keeps its last level
// [R4] host may toggle one input at 250kbps
// [R5] standard receivers invert and can tri-state
// [R6] monitor receiver non-inverting, always enabled
// [R7] inverting receivers off only in manual powerdown
// [R8] auto mode: transmitters on after recent edge
// [R9] both force inputs high: always fully active
// [R10] low shutdown input forces manual powerdown
// [R11] host holds active input high for manual-only
// [R12] host may drive only the shutdown input
// [R13] tied force inputs act as one shutdown
// [R14] powerdown turns off the charge pump
// [R15] force inputs from flag: active while valid
// [R16] host disables receivers into dead peripherals
// [R17] flag low after 60us of invalid levels
// [R18] flag high 1us after valid level seen
// [R19] any input edge wakes from auto powerdown
// [R20] timer stays expired after any powerdown entry
// [R21] every input edge restarts inactivity timer
// [R22] edge detection uses synchronised input copies
module serial_transceiver_power_control
  import xcvr_pwr_pkg::*;
#(
  parameter int unsigned N_TX = NUM_TX,
  parameter int unsigned N_RX = NUM_RX,
  parameter longint unsigned IDLE_COUNT = IDLE_CYCLES,
  parameter int unsigned INVALID_COUNT = INVALID_CYCLES,
  parameter int unsigned VALID_COUNT = VALID_CYCLES,
  parameter int unsigned TX_FIFO_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // power control pins
  input wire logic force_active_in,
  input wire logic force_shutdown_in,
  // transmitter logic inputs with drive indication
  input wire logic [N_TX-1:0] tx_in,
  input wire logic [N_TX-1:0] tx_in_driven,
  // transmitter line outputs, oe low while driving
  output logic [N_TX-1:0] tx_line_out,
  output logic [N_TX-1:0] tx_line_oe_n,
  // receiver line inputs and valid-level detectors
  input wire logic [N_RX-1:0] rx_line_in,
  input wire logic [N_RX-1:0] rx_level_valid,
  input wire logic monitor_rx_line_in,
  input wire logic monitor_rx_level_valid,
  // receiver logic outputs, oe low while driving
  output logic [N_RX-1:0] rx_out,
  output logic [N_RX-1:0] rx_out_oe_n,
  output logic monitor_rx_out,
  // status
  output logic no_valid_level_flag,
  output logic charge_pump_en,
  output logic [1:0] power_mode,
  // transmitter stream: sampled inputs enter a fifo
  output logic tx_fifo_ready
);
  localparam int unsigned IW = 64;
  localparam int unsigned VW = $clog2(INVALID_COUNT + 1) + 1;

  typedef struct packed {
    logic [N_TX-1:0] tx_s1;
    logic [N_TX-1:0] tx_s2;
    logic [N_TX-1:0] drv_s1;
    logic [N_TX-1:0] drv_s2;
    logic [N_TX-1:0] tx_hold;
    logic [N_TX-1:0] tx_prev;
    logic [N_RX:0] rx_s1;
    logic [N_RX:0] rx_s2;
    logic [N_RX:0] rx_prev;
    logic [N_RX:0] vld_s1;
    logic [N_RX:0] vld_s2;
    logic [IW-1:0] idle_cnt;
    logic idle_expired;
    logic fa_prev;
    logic [VW-1:0] inv_cnt;
    logic [VW-1:0] val_cnt;
    logic flag;
    pwr_mode_t mode;
    logic [N_TX-1:0] tx_line;
    logic [N_TX-1:0] tx_oe_n;
    logic [N_RX-1:0] rx_o;
    logic [N_RX-1:0] rx_oe_n;
    logic mon;
    logic pump;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  // fifo between sampled transmitter data and the line drivers
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [N_TX-1:0] fifo_out_data;
  logic tx_enabled;

  // any bit set in a vector; used for edges and valid levels alike
  function automatic logic any_set(input logic [N_TX+N_RX:0] v);
    any_set = |v;
  endfunction : any_set

  sync_fifo #(
    .WIDTH(N_TX),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(st.tx_hold != st.tx_prev),
    .in_ready(fifo_in_ready),
    .in_data(st.tx_hold),
    .out_valid(fifo_out_valid),
    .out_ready(tx_enabled),
    .out_data(fifo_out_data)
  );

  assign tx_enabled = (st.mode == MODE_ACTIVE);

  // =====================================================
  // next-state logic
  always_comb begin
    logic edge_seen;
    logic any_valid;
    logic manual;
    logic [N_TX-1:0] tx_edges;
    logic [N_RX:0] rx_edges;
    edge_seen = 1'b0;
    any_valid = 1'b0;
    manual = 1'b0;
    tx_edges = '0;
    rx_edges = '0;
    next_st = st;

    // two-flop synchronisers; only stage two is looked at
    next_st.tx_s1 = tx_in;
    next_st.tx_s2 = st.tx_s1;
    // drive indication rides the same two stages, so it always qualifies the matching data
    next_st.drv_s1 = tx_in_driven;
    next_st.drv_s2 = st.drv_s1;
    next_st.rx_s1 = {monitor_rx_line_in, rx_line_in};
    next_st.rx_s2 = st.rx_s1;
    next_st.vld_s1 = {monitor_rx_level_valid, rx_level_valid};
    next_st.vld_s2 = st.vld_s1;
    next_st.rx_prev = st.rx_s2;
    next_st.fa_prev = force_active_in;

    // keeper: floating inputs retain their last driven level
    for (int i = 0; i < N_TX; i++) begin
      if (st.drv_s2[i]) begin
        next_st.tx_hold[i] = st.tx_s2[i]; // R3
      end
    end
    // tx_prev tracks what the fifo has accepted, so back-pressure holds the edge
    if (fifo_in_ready) begin
      next_st.tx_prev = st.tx_hold;
    end

    // edge detection on synchronised copies
    tx_edges = st.tx_hold ^ st.tx_prev; // R22
    rx_edges = st.rx_s2 ^ st.rx_prev; // R22
    edge_seen = any_set({tx_edges, rx_edges});
    any_valid = any_set({{N_TX{1'b0}}, st.vld_s2});

    // inactivity timer: restart on an edge, stay expired once set
    if (edge_seen) begin
      next_st.idle_cnt = '0; // R21
      next_st.idle_expired = 1'b0; // R19
    end else if (force_active_in && !st.fa_prev) begin
      next_st.idle_cnt = '0; // R20
      next_st.idle_expired = 1'b0;
    end else if (!st.idle_expired) begin
      if (st.idle_cnt >= IW'(IDLE_COUNT - 1)) begin
        next_st.idle_expired = 1'b1; // R8
      end else begin
        next_st.idle_cnt = st.idle_cnt + 1'b1;
      end
    end
    // entering any powerdown leaves the timer timed out
    if (st.mode != MODE_ACTIVE && !edge_seen && !(force_active_in && !st.fa_prev)) begin
      next_st.idle_expired = 1'b1; // R20
    end

    // invalid-level flag, runs in every mode
    if (any_valid) begin
      next_st.inv_cnt = '0;
      if (st.val_cnt >= VW'(VALID_COUNT)) begin
        next_st.flag = 1'b1; // R18
      end else begin
        next_st.val_cnt = st.val_cnt + 1'b1;
      end
    end else begin
      next_st.val_cnt = '0;
      if (st.inv_cnt >= VW'(INVALID_COUNT)) begin
        next_st.flag = 1'b0; // R17
      end else begin
        next_st.inv_cnt = st.inv_cnt + 1'b1;
      end
    end

    // mode decision; shutdown overrides, tied pins behave as one shutdown
    manual = !force_shutdown_in; // R10 R13 R15
    if (manual) begin
      next_st.mode = MODE_MANUAL_DOWN; // R10
    end else if (force_active_in) begin
      next_st.mode = MODE_ACTIVE; // R9 R13 R15
    end else if (edge_seen || !next_st.idle_expired) begin
      next_st.mode = MODE_ACTIVE; // R8 R19
    end else begin
      next_st.mode = MODE_AUTO_DOWN; // R8
    end

    // output drive
    case (next_st.mode)
      MODE_ACTIVE: begin
        next_st.tx_oe_n = '0;
        next_st.rx_oe_n = '0;
        next_st.pump = 1'b1;
      end
      MODE_AUTO_DOWN: begin
        next_st.tx_oe_n = '1; // R2
        next_st.rx_oe_n = '0; // R7
        next_st.pump = 1'b0; // R14
      end
      MODE_MANUAL_DOWN: begin
        next_st.tx_oe_n = '1; // R2
        next_st.rx_oe_n = '1; // R7
        next_st.pump = 1'b0; // R14
      end
      default: begin
        next_st.tx_oe_n = '1;
        next_st.rx_oe_n = '1;
        next_st.pump = 1'b0;
      end
    endcase
    // transmitters invert the data drained from the fifo
    if (fifo_out_valid && tx_enabled) begin
      next_st.tx_line = ~fifo_out_data; // R1
    end
    next_st.rx_o = ~st.rx_s2[N_RX-1:0]; // R5
    next_st.mon = st.rx_s2[N_RX]; // R6
  end

  // =====================================================
  // state register; all outputs but tx_fifo_ready come off these flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.tx_line <= '1;
      st.tx_oe_n <= '1;
      st.rx_oe_n <= '1;
      st.mode <= MODE_MANUAL_DOWN;
    end else begin
      st <= next_st;
    end
  end

  assign tx_line_out = st.tx_line;
  assign tx_line_oe_n = st.tx_oe_n;
  assign rx_out = st.rx_o;
  assign rx_out_oe_n = st.rx_oe_n;
  assign monitor_rx_out = st.mon;
  assign no_valid_level_flag = st.flag;
  assign charge_pump_en = st.pump;
  assign power_mode = st.mode;
  assign tx_fifo_ready = fifo_in_ready;
endmodule : serial_transceiver_power_control

// file: tb/stpc_properties.sv
// checker: port-level properties of the transceiver power control
`timescale 1ns/10ps
module stpc_properties
  import xcvr_pwr_pkg::*;
#(
  parameter int unsigned INVALID_COUNT = INVALID_CYCLES,
  parameter int unsigned VALID_COUNT = VALID_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pins watched
  input wire logic force_active_in,
  input wire logic force_shutdown_in,
  input wire logic [NUM_TX-1:0] tx_line_oe_n,
  input wire logic [NUM_RX-1:0] rx_line_in,
  input wire logic [NUM_RX-1:0] rx_level_valid,
  input wire logic monitor_rx_line_in,
  input wire logic monitor_rx_level_valid,
  input wire logic [NUM_RX-1:0] rx_out,
  input wire logic [NUM_RX-1:0] rx_out_oe_n,
  input wire logic monitor_rx_out,
  input wire logic no_valid_level_flag,
  input wire logic charge_pump_en,
  input wire logic [1:0] power_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  int unsigned up;
  int unsigned bad;
  int unsigned good;
  logic any_valid;
  assign any_valid = (|rx_level_valid) | monitor_rx_level_valid;
  // run counters saturate so a long idle stretch never wraps to zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      up <= 0;
      bad <= 0;
      good <= 0;
    end else begin
      up <= (up < 7) ? up + 1 : up;
      bad <= any_valid ? 0 : ((bad < 999) ? bad + 1 : bad);
      good <= !any_valid ? 0 : ((good < 999) ? good + 1 : good);
    end
  end
  // ==========================================
  // mode and enables
  property p_manual;
    !force_shutdown_in |=> power_mode == 2'h2 && (&tx_line_oe_n) && (&rx_out_oe_n) && !charge_pump_en;
  endproperty
  a_manual: assert property (p_manual) else $error("shutdown pin low but device not down");
  property p_on;
    force_shutdown_in && force_active_in |=> power_mode == 2'h0 && tx_line_oe_n == '0 && rx_out_oe_n == '0;
  endproperty
  a_on: assert property (p_on) else $error("both force pins high but device not active");
  property p_down_tx;
    power_mode != 2'h0 |-> (&tx_line_oe_n) && !charge_pump_en;
  endproperty
  a_down_tx: assert property (p_down_tx) else $error("transmitter or pump on while down");
  property p_auto_rx;
    power_mode == 2'h1 |-> rx_out_oe_n == '0;
  endproperty
  a_auto_rx: assert property (p_auto_rx) else $error("receivers off in auto powerdown");
  // receiver data, three cycles of pipeline after a settled line
  property p_rx;
    up > 6 && $stable(rx_line_in) [*4] |-> rx_out_oe_n != '0 || rx_out == ~rx_line_in;
  endproperty
  a_rx: assert property (p_rx) else $error("receiver output not inverse of line");
  property p_mon;
    up > 6 && $stable(monitor_rx_line_in) [*4] |-> monitor_rx_out == monitor_rx_line_in;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor output not equal to line");
  // valid-level flag against run lengths
  property p_bad;
    bad > INVALID_COUNT + 6 |-> !no_valid_level_flag;
  endproperty
  a_bad: assert property (p_bad) else $error("flag still high after invalid run");
  property p_good;
    good > VALID_COUNT + 6 |-> no_valid_level_flag;
  endproperty
  a_good: assert property (p_good) else $error("flag still low after valid run");
endmodule : stpc_properties

bind serial_transceiver_power_control stpc_properties #(
  .INVALID_COUNT(INVALID_COUNT),
  .VALID_COUNT(VALID_COUNT)
) u_props (
  .core_clk, .rstn, .force_active_in, .force_shutdown_in, .tx_line_oe_n,
  .rx_line_in, .rx_level_valid, .monitor_rx_line_in, .monitor_rx_level_valid,
  .rx_out, .rx_out_oe_n, .monitor_rx_out, .no_valid_level_flag, .charge_pump_en, .power_mode
);

// file: tb/rs232_remote.sv
// remote line equipment model driving the receiver inputs
`timescale 1ns/10ps
module rs232_remote
  import xcvr_pwr_pkg::*;
(
  // control from the bench
  input wire logic core_clk,
  input wire logic attached,
  input wire logic slow,
  input wire logic [NUM_RX:0] lvl,
  // receiver line side
  output logic [NUM_RX-1:0] rx_line_in,
  output logic [NUM_RX-1:0] rx_level_valid,
  output logic monitor_rx_line_in,
  output logic monitor_rx_level_valid
);
  logic [NUM_RX:0] lag;
  // a detached cable reads as the pull-down level, never the last value
  always @(posedge core_clk) begin
    lag <= lvl;
    {monitor_rx_line_in, rx_line_in} <= attached ? (slow ? lag : lvl) : '0;
    {monitor_rx_level_valid, rx_level_valid} <= attached ? '1 : '0;
  end
endmodule : rs232_remote

// file: tb/serial_transceiver_power_control_tb.sv
// self-checking bench for the transceiver power control
`timescale 1ns/10ps
module serial_transceiver_power_control_tb
  import xcvr_pwr_pkg::*;
;
  localparam int IDLE = 200;
  localparam int BIT = 200; // one bit time at 250kbps
  logic core_clk = 0;
  logic rstn = 0;
  logic force_active_in = 1;
  logic force_shutdown_in = 1;
  logic [NUM_TX-1:0] tx_in = '0;
  logic [NUM_TX-1:0] tx_in_driven = '1;
  logic attached = 1;
  logic slow = 0;
  logic [NUM_RX:0] lvl = '0;
  logic [NUM_TX-1:0] tx_line_out, tx_line_oe_n;
  logic [NUM_RX-1:0] rx_line_in, rx_level_valid, rx_out, rx_out_oe_n;
  logic monitor_rx_line_in, monitor_rx_level_valid, monitor_rx_out;
  logic no_valid_level_flag, charge_pump_en, tx_fifo_ready;
  logic [1:0] power_mode;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  serial_transceiver_power_control #(.IDLE_COUNT(IDLE), .INVALID_COUNT(20), .VALID_COUNT(5)) u_dut (
    .core_clk, .rstn, .force_active_in, .force_shutdown_in, .tx_in, .tx_in_driven, .tx_line_out,
    .tx_line_oe_n, .rx_line_in, .rx_level_valid, .monitor_rx_line_in, .monitor_rx_level_valid,
    .rx_out, .rx_out_oe_n, .monitor_rx_out, .no_valid_level_flag, .charge_pump_en, .power_mode,
    .tx_fifo_ready
  );
  rs232_remote u_remote (
    .core_clk, .attached, .slow, .lvl, .rx_line_in, .rx_level_valid,
    .monitor_rx_line_in, .monitor_rx_level_valid
  );
  // ==========================================
  // common tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // force pins follow the flag, as when both are wired to it
  task automatic follow(input int n);
    repeat (n) begin
      @(posedge core_clk);
      force_active_in <= no_valid_level_flag;
      force_shutdown_in <= no_valid_level_flag;
    end
  endtask : follow
  // ==========================================
  // scenarios
  task automatic t_reset;
    tick(20);
    check(tx_line_oe_n, 8'h1f);
    check(rx_out_oe_n, 8'h07);
    check(power_mode, 8'h02);
    check(no_valid_level_flag, 8'h00);
    check(charge_pump_en, 8'h00);
    rstn <= 1;
    tick(2);
  endtask : t_reset
  task automatic t_on;
    lvl <= 4'ha;
    tx_in <= 5'h15;
    tick(12);
    check(tx_line_out, 8'h0a);
    check(tx_line_oe_n, 8'h00);
    check(rx_out, 8'h05);
    check(monitor_rx_out, 8'h01);
    check(charge_pump_en, 8'h01);
  endtask : t_on
  task automatic t_manual;
    for (int i = 0; i < 2; i++) begin
      force_active_in <= i[0];
      force_shutdown_in <= 1'b0;
      tick(4);
      check(power_mode, 8'h02);
      check(tx_line_oe_n, 8'h1f);
      check(rx_out_oe_n, 8'h07);
      lvl <= lvl ^ 4'h8;
      tick(6);
      check(monitor_rx_out, {7'h00, lvl[3]});
    end
  endtask : t_manual
  // edges wait in the fifo while down, then drain once active
  task automatic t_fifo;
    for (int i = 0; i < 9; i++) begin
      tx_in <= tx_in ^ 5'h01;
      tick(BIT);
    end
    check(tx_fifo_ready, 8'h00);
    force_shutdown_in <= 1'b1;
    tick(30);
    check(tx_fifo_ready, 8'h01);
    check(tx_line_out, 8'h0b);
  endtask : t_fifo
  task automatic t_keep;
    tx_in_driven <= '0;
    tx_in <= 5'h00;
    tick(12);
    check(tx_line_out, 8'h0b);
    tx_in <= 5'h14;
    tx_in_driven <= '1;
    tick(2);
  endtask : t_keep
  task automatic t_auto;
    force_active_in <= 1'b0;
    tick(IDLE + 10);
    check(power_mode, 8'h01);
    check(tx_line_oe_n, 8'h1f);
    check(rx_out_oe_n, 8'h00);
    tick(100);
    check(power_mode, 8'h01);
    lvl <= lvl ^ 4'h1;
    tick(8);
    check(power_mode, 8'h00);
    tick(150);
    tx_in <= tx_in ^ 5'h02;
    tick(150);
    check(power_mode, 8'h00);
    tick(80);
    check(power_mode, 8'h01);
  endtask : t_auto
  task automatic t_flag;
    slow <= 1'b1;
    attached <= 1'b0;
    follow(45);
    check(no_valid_level_flag, 8'h00);
    check(power_mode, 8'h02);
    check(rx_out_oe_n, 8'h07);
    attached <= 1'b1;
    follow(20);
    check(no_valid_level_flag, 8'h01);
    check(power_mode, 8'h00);
  endtask : t_flag
  // ==========================================
  // clock, watchdog and main sequence
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    t_reset();
    t_on();
    t_manual();
    t_fifo();
    t_keep();
    t_auto();
    t_flag();
    finish_test();
  end
endmodule : serial_transceiver_power_control_tb
